// >>> rtl/smbus_alert_consts.svh
// constants of the alert-response two-wire slave: addresses, pointers, field positions
// assumes inclusion by bare name from the slave module, the master model and the testbench
`ifndef SMBUS_ALERT_CONSTS_SVH
`define SMBUS_ALERT_CONSTS_SVH

`define DEV_ADDR        7'h64
`define ARA_ADDR        7'h0C
`define PTR_STATUS      8'h00
`define PTR_CHARGE_MSB  8'h02
`define PTR_CHARGE_LSB  8'h03
`define PTR_VOLT_MSB    8'h08
`define PTR_VOLT_LSB    8'h09
`define BIT_LAST        3'h7
`define RW_BIT          0
`define UNMAPPED_DATA   8'h00
`define CHARGE_RST      8'h00

`endif

// >>> rtl/smbus_alert_pkg.sv
// types shared by the alert-response slave modules
// uses nothing from the constants header; the modules include it themselves
`default_nettype none
package smbus_alert_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ADDR  = 4'h1,
        ST_ACKW  = 4'h2,
        ST_ACKD  = 4'h3,
        ST_RX    = 4'h4,
        ST_TX    = 4'h5,
        ST_MACK  = 4'h6,
        ST_TXLD  = 4'h7,
        ST_WAITP = 4'h8
    } slv_state_e;
    typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// >>> rtl/bus_cond_if.sv
// bundle of bus events from the line watcher to the slave state machine
// assumes both ends run on ref_clk
`default_nettype none
interface bus_cond_if;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sdaLvl;
    modport det (output sclRise, output sclFall, output startSeen, output stopSeen,
                 output sdaLvl);
    modport fsm (input sclRise, input sclFall, input startSeen, input stopSeen,
                 input sdaLvl);
endinterface
`default_nettype wire

// >>> rtl/bus_cond_det.sv
// line watcher: clock edges, start and stop conditions of the two-wire bus
// assumes scl and sda already synchronous to ref_clk
`default_nettype none
module bus_cond_det (
    input  wire logic ref_clk,    // system clock
    input  wire logic rst_b,      // async reset, active low
    input  wire logic sclIn,      // bus clock level
    input  wire logic sdaIn,      // bus data level
    bus_cond_if.det   bc          // decoded events
);
    logic sclPrev_ff;
    logic sdaPrev_ff;

    // idle-high reset so a bus already idle gives no false edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclPrev_ff <= sclIn;
            sdaPrev_ff <= sdaIn;
        end
    end

    assign bc.sclRise   = sclIn & ~sclPrev_ff;
    assign bc.sclFall   = ~sclIn & sclPrev_ff;
    assign bc.startSeen = sclIn & sclPrev_ff & sdaPrev_ff & ~sdaIn;
    assign bc.stopSeen  = sclIn & sclPrev_ff & ~sdaPrev_ff & sdaIn;
    assign bc.sdaLvl    = sdaIn;

    startStop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (bc.startSeen || bc.stopSeen) |-> sclIn && $past(sclIn) && sdaIn != $past(sdaIn))
        else $error("start or stop decoded without a data change at clock high");
endmodule
`default_nettype wire

// >>> rtl/smbus_alert_slave.sv
// two-wire slave with register reads and alert-response arbitration
// assumes bus pins synchronous to ref_clk and external pull-ups on all lines
`default_nettype none
`include "smbus_alert_consts.svh"

module smbus_alert_slave (
    input  wire logic                  ref_clk,      // 50 MHz system clock
    input  wire logic                  rst_b,        // async reset, active low
    input  wire logic                  sclIn,        // bus clock level
    input  wire logic                  sdaIn,        // bus data level
    output var  logic                  sdaOut,       // data drive value, always low
    output var  logic                  sdaOe,        // high while pulling data low
    output var  logic                  alertPinOut,  // alert drive value, always low
    output var  logic                  alertPinOe,   // high while pulling alert low
    input  wire logic                  alertEvent,   // pulse: new alert event
    input  wire logic                  alertModeEn,  // alert pin in alert mode
    input  wire smbus_alert_pkg::byte_t statusIn,    // live status flags
    input  wire logic [15:0]           voltageIn,    // live voltage result
    input  wire logic [15:0]           chargeIn,     // charge value from core
    input  wire logic                  chargeLoad,   // pulse: take chargeIn
    output var  logic [15:0]           chargeOut     // charge register contents
);
    import smbus_alert_pkg::*;

    bus_cond_if bc ();

    bus_cond_det u_det (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .bc      (bc)
    );

    slv_state_e state_ff;
    logic [2:0] bitCnt_ff;
    byte_t      rxSh_ff;
    byte_t      txSh_ff;
    byte_t      ptr_ff;
    logic       rdMode_ff;
    logic       araMode_ff;
    logic       cmdDone_ff;
    logic       sdaOe_ff;
    logic       alertActive_ff;
    logic       alertPinOe_ff;
    byte_t      chargeByte_ff [2];

    logic       busy;
    byte_t      rxByte;
    byte_t      rdData;
    byte_t      loadByte;
    logic       lastBit;
    logic       arbLost;
    logic       araWin;
    logic       rxWrite;
    logic       txLoad;

    assign busy     = ~bc.startSeen & ~bc.stopSeen;
    assign rxByte   = {rxSh_ff[6:0], bc.sdaLvl};
    assign lastBit  = (bitCnt_ff == `BIT_LAST);
    // only the alert answer arbitrates; a plain read has one addressed slave
    assign arbLost  = busy && state_ff == ST_TX && bc.sclRise && araMode_ff
                      && txSh_ff[7] && !bc.sdaLvl;
    assign araWin   = busy && state_ff == ST_TX && bc.sclRise && araMode_ff
                      && lastBit && !arbLost;
    assign rxWrite  = busy && state_ff == ST_RX && bc.sclRise && lastBit && cmdDone_ff;
    assign txLoad   = busy && bc.sclFall
                      && ((state_ff == ST_ACKD && rdMode_ff) || state_ff == ST_TXLD);
    assign loadByte = araMode_ff ? {`DEV_ADDR, 1'b0} : rdData;

    always_comb begin
        case (ptr_ff)
            `PTR_STATUS:     rdData = statusIn;
            `PTR_CHARGE_MSB: rdData = chargeByte_ff[1];
            `PTR_CHARGE_LSB: rdData = chargeByte_ff[0];
            `PTR_VOLT_MSB:   rdData = voltageIn[15:8];
            `PTR_VOLT_LSB:   rdData = voltageIn[7:0];
            default:         rdData = `UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff   <= ST_IDLE;
            bitCnt_ff  <= 3'h0;
            rxSh_ff    <= 8'h00;
            txSh_ff    <= 8'h00;
            rdMode_ff  <= 1'b0;
            araMode_ff <= 1'b0;
            cmdDone_ff <= 1'b0;
            sdaOe_ff   <= 1'b0;
        end else if (bc.startSeen) begin
            // a repeated start restarts address reception from any state
            state_ff   <= ST_ADDR;
            bitCnt_ff  <= 3'h0;
            araMode_ff <= 1'b0;
            sdaOe_ff   <= 1'b0;
        end else if (bc.stopSeen) begin
            state_ff <= ST_IDLE;
            sdaOe_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (bc.sclRise) begin
                        rxSh_ff   <= rxByte;
                        bitCnt_ff <= bitCnt_ff + 3'h1;
                        if (lastBit) begin
                            if (rxByte[7:1] == `DEV_ADDR) begin
                                state_ff   <= ST_ACKW;
                                rdMode_ff  <= rxByte[`RW_BIT];
                                // a write address always expects a fresh command byte
                                cmdDone_ff <= rxByte[`RW_BIT];
                            end else if (rxByte[7:1] == `ARA_ADDR && rxByte[`RW_BIT]
                                         && alertPinOe_ff) begin
                                state_ff   <= ST_ACKW;
                                rdMode_ff  <= 1'b1;
                                araMode_ff <= 1'b1;
                            end else begin
                                state_ff <= ST_WAITP;
                            end
                        end
                    end
                end
                ST_ACKW: begin
                    if (bc.sclFall) begin
                        sdaOe_ff <= 1'b1;
                        state_ff <= ST_ACKD;
                    end
                end
                ST_ACKD, ST_TXLD: begin
                    if (bc.sclFall) begin
                        bitCnt_ff <= 3'h0;
                        if (txLoad) begin
                            txSh_ff  <= loadByte;
                            sdaOe_ff <= ~loadByte[7];
                            state_ff <= ST_TX;
                        end else begin
                            sdaOe_ff <= 1'b0;
                            state_ff <= ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (bc.sclRise) begin
                        rxSh_ff   <= rxByte;
                        bitCnt_ff <= bitCnt_ff + 3'h1;
                        if (lastBit) begin
                            cmdDone_ff <= 1'b1;
                            state_ff   <= ST_ACKW;
                        end
                    end
                end
                ST_TX: begin
                    if (arbLost) begin
                        sdaOe_ff <= 1'b0;
                        state_ff <= ST_WAITP;
                    end else if (bc.sclRise) begin
                        bitCnt_ff <= bitCnt_ff + 3'h1;
                        if (lastBit) begin
                            state_ff <= ST_MACK;
                        end
                    end else if (bc.sclFall) begin
                        txSh_ff  <= {txSh_ff[6:0], 1'b0};
                        sdaOe_ff <= ~txSh_ff[6];
                    end
                end
                ST_MACK: begin
                    if (bc.sclFall) begin
                        sdaOe_ff <= 1'b0;
                    end else if (bc.sclRise) begin
                        // master ack keeps a register read going; nack ends it
                        state_ff <= (!bc.sdaLvl && !araMode_ff) ? ST_TXLD : ST_WAITP;
                    end
                end
                ST_IDLE, ST_WAITP: begin
                    sdaOe_ff <= 1'b0;
                end
                default: begin
                    state_ff <= ST_IDLE;
                    sdaOe_ff <= 1'b0;
                end
            endcase
        end
    end

    // pointer: command byte loads it, each written byte or master-acked register-read byte advances it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_ff <= 8'h00;
        end else if (busy && state_ff == ST_RX && bc.sclRise && lastBit) begin
            ptr_ff <= cmdDone_ff ? ptr_ff + 8'h01 : rxByte;
        end else if (busy && state_ff == ST_MACK && bc.sclRise && !bc.sdaLvl
                     && !araMode_ff) begin
            ptr_ff <= ptr_ff + 8'h01;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_charge
            localparam byte_t PTR_I = (i == 1) ? `PTR_CHARGE_MSB : `PTR_CHARGE_LSB;
            // a bus write beats a core load landing in the same cycle
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    chargeByte_ff[i] <= `CHARGE_RST;
                end else if (rxWrite && ptr_ff == PTR_I) begin
                    chargeByte_ff[i] <= rxByte;
                end else if (chargeLoad) begin
                    chargeByte_ff[i] <= chargeIn[i*8 +: 8];
                end
            end
        end
    endgenerate

    // new event wins over a release in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            alertActive_ff <= 1'b0;
        end else if (alertEvent) begin
            alertActive_ff <= 1'b1;
        end else if (araWin) begin
            alertActive_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            alertPinOe_ff <= 1'b0;
        end else begin
            alertPinOe_ff <= alertActive_ff & alertModeEn;
        end
    end

    assign sdaOe       = sdaOe_ff;
    assign sdaOut      = 1'b0;
    assign alertPinOe  = alertPinOe_ff;
    assign alertPinOut = 1'b0;
    assign chargeOut   = {chargeByte_ff[1], chargeByte_ff[0]};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence araAddrSeen;
        state_ff == ST_ADDR && busy && bc.sclRise && lastBit
        && rxByte == {`ARA_ADDR, 1'b1};
    endsequence
    sequence ackWindow;
        state_ff == ST_ACKW ##[1:1000] (state_ff == ST_ACKD && sdaOe_ff);
    endsequence

    araAck_a: assert property ((araAddrSeen and alertPinOe_ff) |=> ackWindow)
        else $error("alert response address not acknowledged");
    araIgnore_a: assert property ((araAddrSeen and !alertPinOe_ff)
        |=> state_ff == ST_WAITP)
        else $error("alert response answered without alert");
    arbAbort_a: assert property (arbLost |=> !sdaOe_ff && state_ff == ST_WAITP)
        else $error("drive kept after lost arbitration");
    lostKeep_a: assert property (arbLost && !alertEvent
        |=> alertActive_ff == $past(alertActive_ff))
        else $error("alert changed after lost arbitration");
    alertRel_a: assert property (araWin && !alertEvent
        |=> !alertActive_ff ##1 !alertPinOe_ff)
        else $error("alert not released after response");
    ptrStep_a: assert property (state_ff == ST_MACK && busy && bc.sclRise && !bc.sdaLvl
        && !araMode_ff |=> ptr_ff == $past(ptr_ff) + 8'h01)
        else $error("pointer not advanced on master ack");
    chargeMsb_a: assert property (txLoad && !araMode_ff && ptr_ff == `PTR_CHARGE_MSB
        |=> txSh_ff == $past(chargeByte_ff[1]) && sdaOe_ff == ~txSh_ff[7])
        else $error("charge high byte not sent first");
    statusSend_a: assert property (txLoad && !araMode_ff && ptr_ff == `PTR_STATUS
        |=> txSh_ff == $past(statusIn))
        else $error("status byte not loaded");
    voltSend_a: assert property (txLoad && !araMode_ff && ptr_ff == `PTR_VOLT_LSB
        |=> txSh_ff == $past(voltageIn[7:0]))
        else $error("voltage low byte not loaded");
    lowOnly_a: assert property (sdaOut == 1'b0 && alertPinOut == 1'b0
        && (!sdaOe_ff || state_ff inside {ST_ACKD, ST_TX, ST_MACK}))
        else $error("data line pulled outside an owned bit or driven high");
endmodule
`default_nettype wire

// >>> dv/i2c_master_model.sv
// two-wire bus master model: register reads and writes, alert response cycles
// assumes pull-ups on both lines are resolved by the bench; it only ever pulls low
`default_nettype none
`include "smbus_alert_consts.svh"
module i2c_master_model
    import smbus_alert_pkg::*;
(
    input  wire logic        ref_clk,   // system clock
    input  wire logic        sdaIn,     // resolved data line
    output var  logic        sclPull,   // high pulls clock low
    output var  logic        sdaPull,   // high pulls data low
    output var  logic        resValid,  // one-cycle result strobe
    output var  logic [15:0] resVal     // ack bit or byte seen
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sclPull  = 1'b0;
        sdaPull  = 1'b0;
        resValid = 1'b0;
        resVal   = 16'h0000;
    end

    task automatic put(input logic [15:0] v);
        resVal   <= v;
        resValid <= 1'b1;
        @(posedge ref_clk);
        resValid <= 1'b0;
    endtask

    // long low phase leaves the slave room to change data after the fall
    task automatic bitx(input logic b, output logic r);
        sdaPull <= ~b;
        repeat (4) @(posedge ref_clk);
        sclPull <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        r = sdaIn;
        repeat (2) @(posedge ref_clk);
        sclPull <= 1'b1;
        @(posedge ref_clk);
    endtask

    // serves as first and repeated start alike
    task automatic start();
        sdaPull <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sclPull <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sdaPull <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sclPull <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic stop();
        sdaPull <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sclPull <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sdaPull <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic wr(input byte_t d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, a);
        put({15'h0000, a});
    endtask

    // a rival slave of lower address shows up as zeros on the data bits
    task automatic rd(input logic last, input logic rival);
        byte_t d;
        logic  r;
        for (int i = 7; i >= 0; i--) begin
            bitx(~rival, d[i]);
        end
        bitx(last, r);
        put({8'h00, d});
    endtask

    task automatic regRd(input byte_t ptr, input int n);
        logic a;
        start();
        wr({`DEV_ADDR, 1'b0}, a);
        wr(ptr, a);
        start();
        wr({`DEV_ADDR, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            rd(i == n - 1, 1'b0);
        end
        stop();
    endtask

    task automatic regWr(input byte_t ptr, input logic [15:0] v);
        logic a;
        start();
        wr({`DEV_ADDR, 1'b0}, a);
        wr(ptr, a);
        wr(v[15:8], a);
        wr(v[7:0], a);
        stop();
    endtask

    task automatic ara(input logic rival);
        logic a;
        start();
        wr({`ARA_ADDR, 1'b1}, a);
        if (a === 1'b0) begin
            rd(1'b1, rival);
        end
        stop();
    endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench: register reads and writes, alert response with arbitration
// assumes the master model is the only clock driver; lines resolve with pull-ups
`default_nettype none
`include "smbus_alert_consts.svh"
module testbench;
    import smbus_alert_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        sclPull, sdaPull, resValid, sdaOut, sdaOe, alertPinOut, alertPinOe;
    logic        alertEvent, alertModeEn, chargeLoad;
    logic [15:0] resVal, voltageIn, chargeIn, chargeOut, w;
    byte_t       statusIn;
    wire         sclBus = ~sclPull;
    wire         sdaBus = ~sdaPull & (sdaOe ? sdaOut : 1'b1);
    string       expName[$];
    logic [15:0] expVal[$];
    int          nFail = 0, checkCount = 0, cycles = 0;

    always #10 ref_clk = ~ref_clk;

    smbus_alert_slave dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .sclIn(sclBus),
        .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .alertPinOut(alertPinOut),
        .alertPinOe(alertPinOe), .alertEvent(alertEvent), .alertModeEn(alertModeEn),
        .statusIn(statusIn), .voltageIn(voltageIn), .chargeIn(chargeIn),
        .chargeLoad(chargeLoad), .chargeOut(chargeOut));

    i2c_master_model mst (.ref_clk(ref_clk), .sdaIn(sdaBus), .sclPull(sclPull),
        .sdaPull(sdaPull), .resValid(resValid), .resVal(resVal));

    task automatic note(input string nm, input logic [15:0] v);
        expName.push_back(nm);
        expVal.push_back(v);
    endtask

    task automatic expRead(input byte_t ptr, input int n, input logic [15:0] v);
        repeat (3) note("ack", 16'h0000);
        if (n == 2) note("msb", {8'h00, v[15:8]});
        note("byte", {8'h00, v[7:0]});
        mst.regRd(ptr, n);
    endtask

    // looks between edges so the flop outputs have settled
    task automatic probe(input string nm, input logic [15:0] v, input logic sel);
        note(nm, v);
        @(negedge ref_clk);
        mst.put(sel ? chargeOut : {15'h0000, alertPinOe & ~alertPinOut});
    endtask

    task automatic pulseEvent();
        alertEvent <= 1'b1;
        @(posedge ref_clk);
        alertEvent <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic wrapUp();
        if (expVal.size() != 0) nFail++;
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        string       nm;
        logic [15:0] ev;
        if (resValid === 1'b1) begin
            nm = (expName.size() > 0) ? expName.pop_front() : "none";
            ev = (expVal.size() > 0) ? expVal.pop_front() : 16'hXXXX;
            checkCount++;
            if (resVal !== ev) begin
                nFail++;
                $display("CHECK FAILED %s expected %0h seen %0h", nm, ev, resVal);
            end
        end
    end

    // whole run needs well under this many cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            nFail++;
            wrapUp();
        end
    end

    initial begin
        alertEvent  = 1'b0;
        alertModeEn = 1'b0;
        chargeLoad  = 1'b0;
        statusIn    = 8'h00;
        voltageIn   = 16'h0000;
        chargeIn    = 16'h0000;
        void'($urandom(33273));
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        statusIn   <= 8'($urandom);
        voltageIn  <= 16'($urandom);
        chargeIn   <= 16'($urandom);
        chargeLoad <= 1'b1;
        @(posedge ref_clk);
        chargeLoad <= 1'b0;
        @(posedge ref_clk);
        expRead(`PTR_STATUS, 1, {8'h00, statusIn});
        expRead(`PTR_VOLT_MSB, 2, voltageIn);
        expRead(`PTR_CHARGE_MSB, 2, chargeIn);
        $display("test reads done");
        w = 16'($urandom);
        repeat (4) note("ack", 16'h0000);
        mst.regWr(`PTR_CHARGE_MSB, w);
        probe("charge", w, 1'b1);
        expRead(`PTR_CHARGE_MSB, 2, w);
        expRead(8'h05, 1, 16'h0000);
        $display("test writes done");
        alertModeEn <= 1'b1;
        note("idle ara ack", 16'h0001);
        mst.ara(1'b0);
        pulseEvent();
        probe("alert", 16'h0001, 1'b0);
        note("ara ack", 16'h0000);
        note("lost byte", 16'h0000);
        mst.ara(1'b1);
        probe("alert kept", 16'h0001, 1'b0);
        note("ara ack", 16'h0000);
        note("address", {8'h00, `DEV_ADDR, 1'b0});
        mst.ara(1'b0);
        probe("alert freed", 16'h0000, 1'b0);
        note("repeat ara ack", 16'h0001);
        mst.ara(1'b0);
        $display("test alert done");
        alertModeEn <= 1'b0;
        pulseEvent();
        note("mode off ack", 16'h0001);
        mst.ara(1'b0);
        $display("test mode done");
        repeat (2) @(posedge ref_clk);
        wrapUp();
    end
endmodule
`default_nettype wire
